/* vmd_regs.sv */
// Serial slave, register bank and drive gating of the vibration motor driver
`timescale 1ns/1ns
`default_nettype none
module vmd_regs (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Analog monitors and run pin
  input wire logic motor_run_in,
  input wire logic undervoltage_lockout_ok_in,
  input wire logic regulator_ok_in,
  input wire logic overheat_clear_in,
  // Drive controls
  output logic motor_pos_out,
  output logic motor_neg_out,
  output vmd_pkg::vmd_cfg_type cfg_out
);
  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  // Idle-high default on bus pins so floating lines look like an idle bus
  logic [5:0] s1_r, s1_nxt, s2_r, s2_nxt;
  logic scl_d_r, scl_d_nxt, sda_d_r, sda_d_nxt;
  logic scl, sda, run, vdd_g, reg_g, ot_g;
  always_comb begin
    s1_nxt = {scl_in, sda_in, motor_run_in, undervoltage_lockout_ok_in, regulator_ok_in, overheat_clear_in};
    s2_nxt = s1_r;
    scl_d_nxt = s2_r[5];
    sda_d_nxt = s2_r[4];
  end
  assign scl = s2_r[5];
  assign sda = s2_r[4];
  assign run = s2_r[3];
  assign vdd_g = s2_r[2];
  assign reg_g = s2_r[1];
  assign ot_g = s2_r[0];
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_r <= 6'h37;
      s2_r <= 6'h37;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else if (clk_en) begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      scl_d_r <= scl_d_nxt;
      sda_d_r <= sda_d_nxt;
    end
  end
  wire scl_rise = scl & ~scl_d_r;
  wire scl_fall = ~scl & scl_d_r;
  wire start_c = scl & scl_d_r & sda_d_r & ~sda;
  wire stop_c = scl & scl_d_r & ~sda_d_r & sda;

  // --------------------------------------------------------------------------
  // Bus slave state machine
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AACK, S_PTR, S_WDATA, S_DACK, S_RDATA, S_RACK} vmd_state_type;
  vmd_state_type st_r, st_nxt;
  logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, ctrl_r, ctrl_nxt, cfg_r, cfg_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic rd_r, rd_nxt, ptr_done_r, ptr_done_nxt, oe_n_r, oe_n_nxt;
  logic [7:0] rdata, stat_v;
  always_comb begin
    stat_v = 8'h00;
    stat_v[vmd_pkg::ST_VDD] = vdd_g;
    stat_v[vmd_pkg::ST_REG] = reg_g;
    stat_v[vmd_pkg::ST_OT] = ot_g;
    case (ptr_r)
      vmd_pkg::OFS_CTRL: rdata = ctrl_r;
      vmd_pkg::OFS_CFG: rdata = cfg_r;
      vmd_pkg::OFS_STAT: rdata = stat_v;
      default: rdata = 8'h00;
    endcase
  end
  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    ptr_nxt = ptr_r;
    rd_nxt = rd_r;
    ptr_done_nxt = ptr_done_r;
    ctrl_nxt = ctrl_r;
    cfg_nxt = cfg_r;
    oe_n_nxt = oe_n_r;
    if (start_c) begin
      st_nxt = S_ADDR;
      bit_nxt = 3'h0;
      oe_n_nxt = 1'b1;
    end else if (stop_c) begin
      st_nxt = S_IDLE;
      oe_n_nxt = 1'b1;
    end else begin
      case (st_r)
        S_IDLE: st_nxt = S_IDLE;
        S_ADDR, S_PTR, S_WDATA: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda};
            bit_nxt = bit_r + 3'h1;
          end
          if (scl_fall && bit_r == 3'h0 && st_r != S_ADDR) begin
            oe_n_nxt = 1'b1;
          end
          if (scl_fall && bit_r == 3'h0 && sh_nxt != sh_r) begin
            oe_n_nxt = 1'b1;
          end
          if (scl_rise && bit_r == vmd_pkg::BIT_LAST) begin
            st_nxt = (st_r == S_ADDR) ? S_AACK : S_DACK;
          end
        end
        S_AACK: begin
          if (scl_fall) begin
            if (sh_r[7:1] == vmd_pkg::DEV_ADDR) begin
              oe_n_nxt = 1'b0;
              rd_nxt = sh_r[0];
              ptr_done_nxt = 1'b0;
            end else begin
              st_nxt = S_IDLE;
            end
          end
          if (scl_rise && !oe_n_r) begin
            st_nxt = rd_r ? S_RDATA : S_PTR;
            bit_nxt = 3'h0;
            sh_nxt = rdata;
          end
        end
        S_DACK: begin
          if (scl_fall) begin
            oe_n_nxt = 1'b0;
            if (!ptr_done_r) begin
              ptr_nxt = sh_r;
              ptr_done_nxt = 1'b1;
            end else begin
              case (ptr_r)
                vmd_pkg::OFS_CTRL: ctrl_nxt = sh_r & vmd_pkg::MASK_CTRL;
                vmd_pkg::OFS_CFG: cfg_nxt = sh_r & vmd_pkg::MASK_CFG;
                default: ctrl_nxt = ctrl_r;
              endcase
              ptr_nxt = ptr_r + 8'h01;
            end
          end
          if (scl_rise) begin
            st_nxt = S_WDATA;
            bit_nxt = 3'h0;
          end
        end
        S_RDATA: begin
          if (scl_fall) begin
            // Enable held until the next fall, so SDA never moves while SCL is high
            oe_n_nxt = sh_r[7];
          end
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], 1'b0};
            bit_nxt = bit_r + 3'h1;
            if (bit_r == vmd_pkg::BIT_LAST) begin
              st_nxt = S_RACK;
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
        S_RACK: begin
          if (scl_fall) begin
            oe_n_nxt = 1'b1;
          end
          if (scl_rise) begin
            st_nxt = sda ? S_IDLE : S_RDATA;
            bit_nxt = 3'h0;
            sh_nxt = rdata;
          end
        end
        default: st_nxt = S_IDLE;
      endcase
    end
  end
  // --------------------------------------------------------------------------
  // Drive gating
  // --------------------------------------------------------------------------
  // Register contents are never touched by the thermal path
  logic pos_r, pos_nxt, neg_r, neg_nxt;
  vmd_pkg::vmd_cfg_type cfg_o_r, cfg_o_nxt;
  always_comb begin
    cfg_o_nxt.drive_en = ctrl_r[vmd_pkg::BIT_EN];
    cfg_o_nxt.overdrive_on = ctrl_r[vmd_pkg::BIT_OD];
    cfg_o_nxt.overdrive_side_sel = ctrl_r[vmd_pkg::BIT_SIDE];
    cfg_o_nxt.input_res = cfg_r[vmd_pkg::RES_HI:vmd_pkg::RES_LO];
    cfg_o_nxt.regulator_level = cfg_r[vmd_pkg::LVL_HI:vmd_pkg::LVL_LO];
    if (cfg_o_nxt.regulator_level == vmd_pkg::LVL_UNDEF) begin
      cfg_o_nxt.regulator_level = vmd_pkg::LVL_MAX;
    end
    pos_nxt = run & ot_g & vdd_g & ctrl_r[vmd_pkg::BIT_EN];
    neg_nxt = pos_nxt;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= S_IDLE;
      sh_r <= 8'h00;
      bit_r <= 3'h0;
      ptr_r <= vmd_pkg::OFS_CTRL;
      rd_r <= 1'b0;
      ptr_done_r <= 1'b0;
      ctrl_r <= vmd_pkg::RST_CTRL;
      cfg_r <= vmd_pkg::RST_CFG;
      oe_n_r <= 1'b1;
      pos_r <= 1'b0;
      neg_r <= 1'b0;
      cfg_o_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      ptr_r <= ptr_nxt;
      rd_r <= rd_nxt;
      ptr_done_r <= ptr_done_nxt;
      ctrl_r <= ctrl_nxt;
      cfg_r <= cfg_nxt;
      oe_n_r <= oe_n_nxt;
      pos_r <= pos_nxt;
      neg_r <= neg_nxt;
      cfg_o_r <= cfg_o_nxt;
    end
  end
  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Pin level always low; open drain pulls only when enable is low
  assign sda_out = 1'b0;
  assign sda_oe_n = oe_n_r;
  assign motor_pos_out = pos_r;
  assign motor_neg_out = neg_r;
  assign cfg_out = cfg_o_r;
endmodule
`default_nettype wire

/* vmd_pkg.sv */
// Constants and carrier types for the vibration motor driver register bank
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package vmd_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h06;
  localparam logic [7:0] OFS_CTRL = 8'h20;
  localparam logic [7:0] OFS_CFG = 8'h21;
  localparam logic [7:0] OFS_STAT = 8'h22;
  localparam logic [7:0] RST_CTRL = 8'h90;
  localparam logic [7:0] RST_CFG = 8'h2c;
  localparam logic [7:0] RST_STAT = 8'h0e;
  localparam logic [7:0] MASK_CTRL = 8'he0;
  localparam logic [7:0] MASK_CFG = 8'hfc;
  localparam int BIT_EN = 7;
  localparam int BIT_OD = 6;
  localparam int BIT_SIDE = 5;
  localparam int RES_HI = 7;
  localparam int RES_LO = 5;
  localparam int LVL_HI = 4;
  localparam int LVL_LO = 2;
  localparam int ST_VDD = 3;
  localparam int ST_REG = 2;
  localparam int ST_OT = 1;
  localparam logic [2:0] LVL_UNDEF = 3'h7;
  localparam logic [2:0] LVL_MAX = 3'h6;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef struct packed {
    logic drive_en;
    logic overdrive_on;
    logic overdrive_side_sel;
    logic [2:0] input_res;
    logic [2:0] regulator_level;
  } vmd_cfg_type;
  typedef struct packed {
    logic supply_good;
    logic regulator_good;
    logic overheat_clear;
  } vmd_health_type;
endpackage

/* vmd_regs_assertions.sv */
// Port checker for the serial register bank
`timescale 1ns/1ns
`default_nettype none
module vmd_regs_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  // Serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Monitors and drive
  input wire logic motor_run_in,
  input wire logic undervoltage_lockout_ok_in,
  input wire logic regulator_ok_in,
  input wire logic overheat_clear_in,
  input wire logic motor_pos_out,
  input wire logic motor_neg_out,
  input wire vmd_pkg::vmd_cfg_type cfg_out
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  reset_quiet_a: assert property (disable iff (1'b0) srst |=> sda_oe_n && !motor_pos_out)
    else $error("outputs active in reset");
  reset_def_a: assert property ($fell(srst) |=> cfg_out == 9'h10b)
    else $error("defaults missing");
  run_low_a: assert property (!motor_run_in [*4] |-> !motor_pos_out)
    else $error("drive without run");
  run_drive_a: assert property ((motor_run_in && undervoltage_lockout_ok_in && overheat_clear_in
    && cfg_out.drive_en) [*4] |-> motor_pos_out)
    else $error("no drive while run");
  heat_off_a: assert property (!overheat_clear_in [*4] |-> !motor_pos_out)
    else $error("drive while overheated");
  heat_keep_a: assert property (!overheat_clear_in |=> $stable(cfg_out))
    else $error("config lost in shutdown");
  supply_off_a: assert property (!undervoltage_lockout_ok_in [*4] |-> !motor_pos_out)
    else $error("drive under lockout");
  level_cap_a: assert property (cfg_out.regulator_level != 3'h7)
    else $error("undefined level shown");
  pair_same_a: assert property (motor_pos_out == motor_neg_out)
    else $error("outputs differ");
endmodule
`default_nettype wire

/* vmd_host_model.sv */
// Serial bus host model for the register bank
`timescale 1ns/1ns
`default_nettype none
module vmd_host_model (
  // Clock and bus
  input wire logic clk,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  output logic scl_in,
  output logic sda_in
);
  logic sda_m;
  initial scl_in = 1'h1;
  initial sda_m = 1'h1;
  // Pulled-up wire, low if either side pulls
  assign sda_in = sda_m & (sda_oe_n | sda_out);
  task automatic hc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Data moves only while the clock is low
  task automatic bit_x(input logic b, output logic r);
    sda_m = b;
    hc(5);
    scl_in = 1'h1;
    hc(6);
    r = sda_in;
    scl_in = 1'h0;
    hc(2);
  endtask
  // Also serves as repeated start
  task automatic start();
    sda_m = 1'h1;
    hc(3);
    scl_in = 1'h1;
    hc(6);
    sda_m = 1'h0;
    hc(6);
    scl_in = 1'h0;
    hc(3);
  endtask
  task automatic stop();
    sda_m = 1'h0;
    hc(3);
    scl_in = 1'h1;
    hc(6);
    sda_m = 1'h1;
    hc(6);
  endtask
  task automatic byte_x(input logic [7:0] d, input logic m, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(m, k);
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Top testbench for the register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic clk_en = 1'h1;
  logic motor_run_in = 1'h0;
  logic undervoltage_lockout_ok_in = 1'h1;
  logic regulator_ok_in = 1'h1;
  logic overheat_clear_in = 1'h1;
  logic scl_in, sda_in, sda_out, sda_oe_n, motor_pos_out, motor_neg_out, k;
  vmd_pkg::vmd_cfg_type cfg_out;
  logic [7:0] q;
  int bad_count = 0;
  int samples_checked = 0;
  always #50 clk = ~clk;
  vmd_regs vmd_regs_i (.clk(clk), .srst(srst), .clk_en(clk_en), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .motor_run_in(motor_run_in),
    .undervoltage_lockout_ok_in(undervoltage_lockout_ok_in), .regulator_ok_in(regulator_ok_in),
    .overheat_clear_in(overheat_clear_in), .motor_pos_out(motor_pos_out),
    .motor_neg_out(motor_neg_out), .cfg_out(cfg_out));
  vmd_host_model vmd_host_model_i (.clk(clk), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .scl_in(scl_in), .sda_in(sda_in));
  task automatic check(input string n, input logic [8:0] s, input logic [8:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic put(input logic [7:0] d);
    vmd_host_model_i.byte_x(d, 1'h1, q, k);
    check("ack", 9'(k), 9'h0);
  endtask
  task automatic get(input logic [7:0] e, input logic last);
    vmd_host_model_i.byte_x(8'hff, last, q, k);
    check("read", 9'(q), 9'(e));
  endtask
  task automatic open_rd(input logic [7:0] p);
    vmd_host_model_i.start();
    put({vmd_pkg::DEV_ADDR, 1'h0});
    put(p);
    vmd_host_model_i.start();
    put({vmd_pkg::DEV_ADDR, 1'h1});
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    vmd_host_model_i.start();
    put({vmd_pkg::DEV_ADDR, 1'h0});
    put(p);
    put(d);
    vmd_host_model_i.stop();
  endtask
  task automatic motor(input logic e);
    repeat (6) @(negedge clk);
    check("pos", 9'(motor_pos_out), 9'(e));
    check("neg", 9'(motor_neg_out), 9'(e));
  endtask
  task automatic t_idle();
    check("cfg", cfg_out, 9'h10b);
    check("sda level", 9'(sda_out), 9'h0);
    motor(1'h0);
    motor_run_in = 1'h1;
    motor(1'h1);
    motor_run_in = 1'h0;
    motor(1'h0);
  endtask
  task automatic t_addr();
    vmd_host_model_i.start();
    vmd_host_model_i.byte_x({vmd_pkg::DEV_ADDR ^ 7'h01, 1'h0}, 1'h1, q, k);
    check("nack", 9'(k), 9'h1);
    vmd_host_model_i.stop();
  endtask
  // One burst runs past status into unmapped space
  task automatic t_regs();
    vmd_host_model_i.start();
    put({vmd_pkg::DEV_ADDR, 1'h0});
    put(vmd_pkg::OFS_CTRL);
    repeat (4) put(8'hff);
    vmd_host_model_i.stop();
    check("cfg", cfg_out, 9'h1fe);
    open_rd(vmd_pkg::OFS_CTRL);
    get(8'he0, 1'h0);
    get(8'hfc, 1'h0);
    get(8'h0e, 1'h0);
    get(8'h00, 1'h1);
    vmd_host_model_i.stop();
  endtask
  task automatic t_status();
    logic [2:0] v;
    motor_run_in = 1'h1;
    for (int b = 0; b < 3; b++) begin
      v = ~(3'h1 << b);
      {undervoltage_lockout_ok_in, regulator_ok_in, overheat_clear_in} = v;
      open_rd(vmd_pkg::OFS_STAT);
      get({4'h0, v, 1'h0}, 1'h1);
      vmd_host_model_i.stop();
      motor(b == 1);
      check("keep", cfg_out, 9'h1fe);
    end
    {undervoltage_lockout_ok_in, regulator_ok_in, overheat_clear_in} = 3'h7;
    motor(1'h1);
  endtask
  task automatic t_fields();
    wr(vmd_pkg::OFS_CTRL, 8'h5f);
    wr(vmd_pkg::OFS_CFG, 8'h1b);
    check("cfg", cfg_out, 9'h086);
    motor(1'h0);
    wr(vmd_pkg::OFS_CTRL, 8'ha0);
    check("cfg", cfg_out, 9'h146);
    motor(1'h1);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    srst = 1'h0;
    repeat (4) @(negedge clk);
    t_idle();
    t_addr();
    t_regs();
    t_status();
    t_fields();
    end_of_test();
  end
  // About nine times the expected run
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
endmodule
bind vmd_regs vmd_regs_assertions vmd_regs_assertions_i (.clk(clk), .srst(srst),
  .clk_en(clk_en), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .motor_run_in(motor_run_in), .undervoltage_lockout_ok_in(undervoltage_lockout_ok_in),
  .regulator_ok_in(regulator_ok_in), .overheat_clear_in(overheat_clear_in),
  .motor_pos_out(motor_pos_out), .motor_neg_out(motor_neg_out), .cfg_out(cfg_out));
`default_nettype wire
